// ==== pkg/emzo_pkg.sv ====
// package for the error mask and zone offset register bank
// assumes an 8-bit internal register port behind the serial management interface
package emzo_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] EMZO_GEN_MASK_ADDR = 8'hec;
  localparam logic [7:0] EMZO_MISC_MASK_ADDR = 8'hed;
  localparam logic [7:0] EMZO_Z1A_OFS_ADDR = 8'hee;
  localparam logic [7:0] EMZO_Z2A_OFS_ADDR = 8'hef;

  // ----------------------------------------------------------------
  // reset values of the register fields
  // ----------------------------------------------------------------
  localparam logic [7:0] EMZO_GEN_MASK_RST = 8'hff;
  localparam logic [5:0] EMZO_MISC_MASK_RST = 6'h3f;
  localparam logic [5:0] EMZO_OFS_RST = 6'h00;

  // ----------------------------------------------------------------
  // misc mask field positions
  // ----------------------------------------------------------------
  localparam int EMZO_REG_HOT_ONE_BIT = 0;
  localparam int EMZO_REG_HOT_TWO_BIT = 1;
  localparam int EMZO_AUX_8_BIT = 2;
  localparam int EMZO_AUX_9_BIT = 3;
  localparam int EMZO_CORE_ONE_BIT = 4;
  localparam int EMZO_CORE_TWO_BIT = 5;

  // ----------------------------------------------------------------
  // temperature limits of the 8-bit signed reading
  // ----------------------------------------------------------------
  localparam logic signed [8:0] EMZO_TEMP_MAX = 9'sd127;
  localparam logic signed [8:0] EMZO_TEMP_MIN = -9'sd128;

  // raw error events from the monitor core
  typedef struct packed {
    logic [7:0] general_input;   // general inputs 0..7
    logic regulator_hot_one;
    logic regulator_hot_two;
    logic aux_general_input_8;
    logic aux_general_input_9;
    logic core_limit_one;        // analog input 7 dynamic limit
    logic core_limit_two;        // analog input 8 dynamic limit
  } emzo_events_t;

  // register port request
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } emzo_reg_req_t;

endpackage : emzo_pkg

// ==== src/emzo_regs.sv ====
// error mask and zone offset register bank with offset adder
// assumes register writes are single-cycle strobes; reads are registered
// address decode registered one cycle later into rdata
`timescale 1ns/1ps
module emzo_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register port
  input wire emzo_pkg::emzo_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // raw events and live levels
  input wire emzo_pkg::emzo_events_t raw_events,
  input wire logic [7:0] general_input_level,
  // temperature measurements
  input wire logic z1a_meas_valid,
  input wire logic signed [7:0] z1a_meas_temp,
  input wire logic z2a_meas_valid,
  input wire logic signed [7:0] z2a_meas_temp,
  // masked events to alert and host status; unmasked live input state
  output emzo_pkg::emzo_events_t alert_events,
  output emzo_pkg::emzo_events_t host_events,
  output logic [7:0] general_input_state,
  // adjusted temperatures
  output logic z1a_adj_valid,
  output logic signed [7:0] z1a_adj_temp,
  output logic z2a_adj_valid,
  output logic signed [7:0] z2a_adj_temp
);
  import emzo_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] general_input_error_mask;   // bit n masks input n
  logic [5:0] misc_error_mask;            // bits 7:6 not stored
  logic [5:0] zone_one_a_offset;          // signed offset
  logic [5:0] zone_two_a_offset;          // signed offset
  logic [7:0] next_gen_mask;
  logic [5:0] next_misc_mask;
  logic [5:0] next_z1a_ofs;
  logic [5:0] next_z2a_ofs;
  logic [7:0] next_rdata;

  // saturating signed add of a 6-bit offset to an 8-bit reading
  function automatic logic [7:0] emzo_sat_add(input logic signed [7:0] t,
                                              input logic [5:0] ofs);
    logic signed [8:0] sum;
    sum = 9'(t) + 9'($signed(ofs));
    if (sum > EMZO_TEMP_MAX)
      emzo_sat_add = EMZO_TEMP_MAX[7:0];
    else if (sum < EMZO_TEMP_MIN)
      emzo_sat_add = EMZO_TEMP_MIN[7:0];
    else
      emzo_sat_add = sum[7:0];
  endfunction : emzo_sat_add

  // ----------------------------------------------------------------
  // register write and read decode
  // ----------------------------------------------------------------
  // writes only touch stored bits; reserved bits drop on the floor
  always_comb
  begin
    next_gen_mask = general_input_error_mask;
    next_misc_mask = misc_error_mask;
    next_z1a_ofs = zone_one_a_offset;
    next_z2a_ofs = zone_two_a_offset;
    next_rdata = 8'h00;                                    // unmapped reads zero
    if (reg_req.wr)
    begin
      if (reg_req.addr == EMZO_GEN_MASK_ADDR)
        next_gen_mask = reg_req.wdata;
      else if (reg_req.addr == EMZO_MISC_MASK_ADDR)
        next_misc_mask = reg_req.wdata[5:0];
      else if (reg_req.addr == EMZO_Z1A_OFS_ADDR)
        next_z1a_ofs = reg_req.wdata[5:0];
      else if (reg_req.addr == EMZO_Z2A_OFS_ADDR)
        next_z2a_ofs = reg_req.wdata[5:0];
    end
    // read view of the current contents
    if (reg_req.addr == EMZO_GEN_MASK_ADDR)
      next_rdata = general_input_error_mask;
    else if (reg_req.addr == EMZO_MISC_MASK_ADDR)
      next_rdata = {2'b00, misc_error_mask};
    else if (reg_req.addr == EMZO_Z1A_OFS_ADDR)
      next_rdata = {2'b00, zone_one_a_offset};
    else if (reg_req.addr == EMZO_Z2A_OFS_ADDR)
      next_rdata = {2'b00, zone_two_a_offset};
  end

  // register stage for the bank
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      general_input_error_mask <= EMZO_GEN_MASK_RST;
      misc_error_mask <= EMZO_MISC_MASK_RST;
      zone_one_a_offset <= EMZO_OFS_RST;
      zone_two_a_offset <= EMZO_OFS_RST;
      reg_rdata <= 8'h00;
    end
    else
    begin
      general_input_error_mask <= next_gen_mask;
      misc_error_mask <= next_misc_mask;
      zone_one_a_offset <= next_z1a_ofs;
      zone_two_a_offset <= next_z2a_ofs;
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // event gating and adjusted temperatures
  // ----------------------------------------------------------------
  emzo_events_t next_masked;
  logic [7:0] next_z1a_temp;
  logic [7:0] next_z2a_temp;

  // one gated copy feeds both status paths so they never disagree
  always_comb
  begin
    next_masked.general_input = raw_events.general_input & ~general_input_error_mask;
    next_masked.regulator_hot_one = raw_events.regulator_hot_one &
                                    ~misc_error_mask[EMZO_REG_HOT_ONE_BIT];
    next_masked.regulator_hot_two = raw_events.regulator_hot_two &
                                    ~misc_error_mask[EMZO_REG_HOT_TWO_BIT];
    next_masked.aux_general_input_8 = raw_events.aux_general_input_8 &
                                      ~misc_error_mask[EMZO_AUX_8_BIT];
    next_masked.aux_general_input_9 = raw_events.aux_general_input_9 &
                                      ~misc_error_mask[EMZO_AUX_9_BIT];
    next_masked.core_limit_one = raw_events.core_limit_one &
                                 ~misc_error_mask[EMZO_CORE_ONE_BIT];
    next_masked.core_limit_two = raw_events.core_limit_two &
                                 ~misc_error_mask[EMZO_CORE_TWO_BIT];
    // adjusted value replaces the raw one for every consumer
    next_z1a_temp = z1a_meas_valid ? emzo_sat_add(z1a_meas_temp, zone_one_a_offset)
                                   : z1a_adj_temp;
    next_z2a_temp = z2a_meas_valid ? emzo_sat_add(z2a_meas_temp, zone_two_a_offset)
                                   : z2a_adj_temp;
  end

  // output registers; temperatures hold until the next measurement
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      alert_events <= '0;
      host_events <= '0;
      general_input_state <= 8'h00;
      z1a_adj_valid <= 1'b0;
      z1a_adj_temp <= 8'h00;
      z2a_adj_valid <= 1'b0;
      z2a_adj_temp <= 8'h00;
    end
    else
    begin
      alert_events <= next_masked;
      host_events <= next_masked;
      general_input_state <= general_input_level;
      z1a_adj_valid <= z1a_meas_valid;
      z1a_adj_temp <= next_z1a_temp;
      z2a_adj_valid <= z2a_meas_valid;
      z2a_adj_temp <= next_z2a_temp;
    end
  end

endmodule : emzo_regs

// ==== verif/emzo_regs_asserts.sv ====
// checker for the mask and offset bank, sees only the top ports
// assumes rising-edge sys_clk and active-low rst_b
`timescale 1ns/1ps
module emzo_regs_chk (
  // clock, reset and inputs
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire emzo_pkg::emzo_reg_req_t reg_req,
  input wire emzo_pkg::emzo_events_t raw_events,
  input wire logic [7:0] general_input_level,
  input wire logic z1a_meas_valid,
  input wire logic signed [7:0] z1a_meas_temp,
  input wire logic z2a_meas_valid,
  input wire logic signed [7:0] z2a_meas_temp,
  // outputs of the bank
  input wire logic [7:0] reg_rdata,
  input wire emzo_pkg::emzo_events_t alert_events,
  input wire emzo_pkg::emzo_events_t host_events,
  input wire logic [7:0] general_input_state,
  input wire logic z1a_adj_valid,
  input wire logic signed [7:0] z1a_adj_temp,
  input wire logic z2a_adj_valid,
  input wire logic signed [7:0] z2a_adj_temp
);
  import emzo_pkg::*;
  // ----------------------------------------------------------------
  // properties; $past(rst_b) skips the edge right after reset
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  a_status_pair_same: assert property (alert_events == host_events)
    else $error("alert and host events differ");
  a_state_stays_live: assert property ($past(rst_b) |-> general_input_state == $past(general_input_level))
    else $error("input state not live");
  a_mask_never_adds: assert property ($past(rst_b) |-> (alert_events & ~$past(raw_events)) == '0)
    else $error("event seen without raw event");
  a_z1_valid_follows: assert property ($past(rst_b) |-> z1a_adj_valid == $past(z1a_meas_valid))
    else $error("zone 1a valid wrong");
  a_z2_valid_follows: assert property ($past(rst_b) |-> z2a_adj_valid == $past(z2a_meas_valid))
    else $error("zone 2a valid wrong");
  a_z1_temp_holds: assert property ($past(rst_b) && !z1a_adj_valid |-> $stable(z1a_adj_temp))
    else $error("zone 1a temp moved");
  a_sat_top_bound: assert property (z1a_adj_valid && $past(z1a_meas_temp) == 8'sh7f |-> z1a_adj_temp >= 8'sh5f)
    else $error("top reading wrapped");
  a_sat_low_bound: assert property (z1a_adj_valid && $past(z1a_meas_temp) == 8'sh80 |-> z1a_adj_temp <= 8'sh9f)
    else $error("bottom reading wrapped");
  a_reserved_read_zero: assert property ($past(rst_b) && $past(reg_req.addr) > EMZO_GEN_MASK_ADDR |-> reg_rdata[7:6] == 2'h0)
    else $error("reserved bits not zero");
  // main scenarios reached
  c_meas_seen: cover property (z1a_adj_valid);
  c_ofs_write: cover property (reg_req.wr && reg_req.addr == EMZO_Z1A_OFS_ADDR);
  c_alert_seen: cover property (alert_events != '0);
endmodule : emzo_regs_chk
bind emzo_regs emzo_regs_chk emzo_regs_chk_i (.sys_clk(sys_clk), .rst_b(rst_b), .reg_req(reg_req),
  .raw_events(raw_events), .general_input_level(general_input_level),
  .z1a_meas_valid(z1a_meas_valid), .z1a_meas_temp(z1a_meas_temp), .z2a_meas_valid(z2a_meas_valid),
  .z2a_meas_temp(z2a_meas_temp), .reg_rdata(reg_rdata), .alert_events(alert_events),
  .host_events(host_events), .general_input_state(general_input_state),
  .z1a_adj_valid(z1a_adj_valid), .z1a_adj_temp(z1a_adj_temp), .z2a_adj_valid(z2a_adj_valid),
  .z2a_adj_temp(z2a_adj_temp));

// ==== verif/tb_top.sv ====
// self-checking bench for the mask and offset bank
// assumes the bank answers reads one cycle after the address
`timescale 1ns/1ps
module tb_top;
  import emzo_pkg::*;
  logic sys_clk = 1'b0, rst_b = 1'b0, z1a_meas_valid = 1'b0, z2a_meas_valid = 1'b0;
  emzo_reg_req_t reg_req = '0;
  emzo_events_t raw_events = '0, alert_events, host_events;
  logic [7:0] general_input_level = 8'h00, reg_rdata, general_input_state;
  logic signed [7:0] z1a_meas_temp = 8'h00, z2a_meas_temp = 8'h00, z1a_adj_temp, z2a_adj_temp;
  logic z1a_adj_valid, z2a_adj_valid;
  int num_errors = 0, n_tests = 0;
  emzo_regs emzo_regs_i (.sys_clk(sys_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .raw_events(raw_events), .general_input_level(general_input_level),
    .z1a_meas_valid(z1a_meas_valid), .z1a_meas_temp(z1a_meas_temp), .z2a_meas_valid(z2a_meas_valid),
    .z2a_meas_temp(z2a_meas_temp), .alert_events(alert_events), .host_events(host_events),
    .general_input_state(general_input_state), .z1a_adj_valid(z1a_adj_valid),
    .z1a_adj_temp(z1a_adj_temp), .z2a_adj_valid(z2a_adj_valid), .z2a_adj_temp(z2a_adj_temp));
  // 100 ns clock
  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // bus tasks start and end at a falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge sys_clk);
    reg_req.wr = 1'b0;
    // let a low cycle pass so a following write never re-raises wr in this step
    @(negedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_req.addr = a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : rd
  task automatic t_defaults;
    logic [7:0] d;
    logic [7:0] exp [5] = '{8'hff, 8'h3f, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++)
    begin
      rd(8'hec + 8'(i), d);
      check(d, exp[i]);
    end
    $display("test defaults done");
  endtask : t_defaults
  task automatic t_masks(input logic [7:0] g, input logic [7:0] m);
    logic [7:0] d;
    emzo_events_t e;
    wr(EMZO_GEN_MASK_ADDR, g);
    wr(EMZO_MISC_MASK_ADDR, m | 8'hc0);
    rd(EMZO_MISC_MASK_ADDR, d);
    check(d, m);
    raw_events = '1;
    general_input_level = g;
    @(negedge sys_clk);
    e = '{~g, ~m[0], ~m[1], ~m[2], ~m[3], ~m[4], ~m[5]};
    check(alert_events, e);
    check(host_events, e);
    check(general_input_state, g);
    raw_events = '0;
    $display("test masks done");
  endtask : t_masks
  task automatic t_offset(input logic [5:0] o, input logic signed [7:0] t);
    logic [7:0] d;
    logic [7:0] x;
    int s;
    s = int'(t) + int'($signed(o));
    x = (s > 127) ? 8'h7f : (s < -128) ? 8'h80 : 8'(s);
    wr(EMZO_Z1A_OFS_ADDR, {2'h3, o});
    wr(EMZO_Z2A_OFS_ADDR, {2'h3, o});
    rd(EMZO_Z2A_OFS_ADDR, d);
    check(d, {2'h0, o});
    {z1a_meas_temp, z2a_meas_temp, z1a_meas_valid, z2a_meas_valid} = {t, t, 2'h3};
    @(negedge sys_clk);
    {z1a_meas_temp, z2a_meas_temp, z1a_meas_valid, z2a_meas_valid} = {~t, ~t, 2'h0};
    check({z1a_adj_valid, z1a_adj_temp}, {1'b1, x});
    check({z2a_adj_valid, z2a_adj_temp}, {1'b1, x});
    @(negedge sys_clk);
    check({z1a_adj_valid, z1a_adj_temp}, {1'b0, x});
    $display("test offset done");
  endtask : t_offset
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  // main sequence, with a second reset mid-run
  initial
  begin
    repeat (8) @(negedge sys_clk);
    rst_b = 1'b1;
    t_defaults();
    t_masks(8'h5a, 8'h2a);
    t_masks(8'ha5, 8'h15);
    t_offset(6'h0f, 8'h7f);
    t_offset(6'h20, 8'h80);
    t_offset(6'h1f, 8'h0a);
    t_offset(6'h3f, 8'h00);
    rst_b = 1'b0;
    @(negedge sys_clk);
    rst_b = 1'b1;
    t_defaults();
    conclude();
  end
endmodule : tb_top
